// ==== core/lookup_access_pkg.sv ====
// Constants, types and register map of the lookup table access port.
// Assumes a byte-wide host register port and a 4096-entry table memory.
package lookup_access_pkg;

    // Register byte addresses
    localparam logic [15:0] KEY_HIGH_OFS = 16'h0410;
    localparam logic [15:0] KEY_LOW_OFS = 16'h0414;
    localparam logic [15:0] ACC_CTRL_OFS = 16'h0418;
    localparam logic [15:0] ENTRY1_OFS = 16'h0420;
    localparam logic [15:0] ENTRY2_OFS = 16'h0424;
    localparam logic [15:0] ENTRY3_OFS = 16'h0428;
    localparam logic [15:0] ENTRY4_OFS = 16'h042C;
    localparam logic [15:0] ENTRY4_LAST_BYTE = 16'h042F;
    localparam logic [15:0] WORD_MASK = 16'hFFFC;

    // Field positions
    localparam int FID_LSB = 16;
    localparam int FID_MSB = 22;
    localparam int MAC_HI_MSB = 15;
    localparam int COUNT_LSB = 16;
    localparam int GO_BIT = 7;
    localparam int READY_BIT = 6;
    localparam int END_BIT = 5;
    localparam int DIRECT_BIT = 2;
    localparam logic [31:0] KEY_HIGH_RW_MASK = 32'h807F_FFFF;
    localparam logic [4:0] CTRL_RW_MASK = 5'h1F;

    // Reset values
    localparam logic [31:0] KEY_HIGH_RST = 32'h0000_0000;
    localparam logic [31:0] KEY_LOW_RST = 32'h0000_0000;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
    localparam logic [13:0] COUNT_RST = 14'h0000;

    // Table geometry
    localparam int TBL_AW = 12;
    localparam int ENTRY_W = 128;
    localparam int ENTRY_VALID_BIT = 127;
    localparam logic [11:0] TBL_LAST = 12'hFFF;

    // Operation field codes
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_SEARCH = 2'b11
    } op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD_WAIT = 3'b001,
        ST_RD_CAP = 3'b010,
        ST_SR_WAIT = 3'b011,
        ST_SR_CAP = 3'b100,
        ST_SR_HOLD = 3'b101
    } state_t;

    // Request toward the table memory
    typedef struct packed {
        logic wr;
        logic rd;
        logic [TBL_AW-1:0] addr;
        logic [ENTRY_W-1:0] wdata;
    } tbl_req_t;

endpackage

// ==== core/lookup_table_access_port.sv ====
// Host access port to the address lookup table: index, control and entry registers.
// Assumes host strobes on the same clock and a table memory with one-cycle read latency.
//
// Functional notes
// - The 7-bit filter group id in bits 22:16 of the key high register feeds the hash.
// - MAC key bits 47:32 come from bits 15:0 of the key high register.
// - MAC key bits 31:0 come from the whole key low register.
// - In direct mode bits 11:0 of the key low register are the table location, no hashing.
// - Operation field bits 1:0: 00 nothing, 01 write, 10 read, 11 search.
// - Software sets go_done_bit (bit 7) to start; hardware clears it when the operation ends.
// - After a search, bits 29:16 hold the number of valid entries found.
// - Bit 6 flags the next search hit in the entry registers; reading 0x042F clears it.
// - Bit 5 reads one when a search hit is ready or the search has ended.
// - Bit 2 selects direct addressing when one, hashed indexing when zero.
// - Reads and search hits fill the four entry registers; writes take data from them.
// - In hashed mode the filter group id and MAC key are hashed together into a location.
`timescale 1ns/1ps
`default_nettype none

module lookup_table_access_port
    import lookup_access_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host byte register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Table memory port
    output tbl_req_t tbl_req,
    input wire logic [ENTRY_W-1:0] tbl_rdata
);

    // Big-endian byte insert: lane 0 is bits 31:24
    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        case (lane)
            2'b00: r[31:24] = b;
            2'b01: r[23:16] = b;
            2'b10: r[15:8] = b;
            default: r[7:0] = b;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
        logic [7:0] r;
        case (lane)
            2'b00: r = w[31:24];
            2'b01: r = w[23:16];
            2'b10: r = w[15:8];
            default: r = w[7:0];
        endcase
        return r;
    endfunction

    // XOR fold of filter group id and MAC key into a table location
    function automatic logic [TBL_AW-1:0] hash_loc(input logic [6:0] filter_group_id, input logic [47:0] mac);
        logic [59:0] k;
        k = {5'h00, filter_group_id, mac};
        return k[11:0] ^ k[23:12] ^ k[35:24] ^ k[47:36] ^ k[59:48];
    endfunction

    logic [31:0] key_high_r, key_high_nxt;
    logic [31:0] key_low_r, key_low_nxt;
    logic [4:0] ctrl_r, ctrl_nxt;
    logic go_r, go_nxt;
    logic ready_r, ready_nxt;
    logic end_r, end_nxt;
    logic [13:0] count_r, count_nxt;
    logic [31:0] entry_r [4];
    logic [31:0] entry_nxt [4];
    logic [TBL_AW-1:0] scan_r, scan_nxt;
    state_t state_r, state_nxt;
    tbl_req_t tbl_req_r, tbl_req_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;
    logic [15:0] word_addr;
    logic [TBL_AW-1:0] loc;
    logic advance;

    // Status view of the control register
    assign ctrl_word = {2'b00, count_r, 8'h00, go_r, ready_r, ready_r | end_r,
                        ctrl_r};
    assign word_addr = reg_addr & WORD_MASK;

    // Table location from the index registers
    assign loc = ctrl_r[DIRECT_BIT] ? key_low_r[TBL_AW-1:0]
               : hash_loc(key_high_r[FID_MSB:FID_LSB],
                          {key_high_r[MAC_HI_MSB:0], key_low_r});

    // Read data mux
    always_comb
    begin
        if (word_addr == KEY_HIGH_OFS)
            rd_word = key_high_r;
        else if (word_addr == KEY_LOW_OFS)
            rd_word = key_low_r;
        else if (word_addr == ACC_CTRL_OFS)
            rd_word = ctrl_word;
        else if (word_addr == ENTRY1_OFS)
            rd_word = entry_r[0];
        else if (word_addr == ENTRY2_OFS)
            rd_word = entry_r[1];
        else if (word_addr == ENTRY3_OFS)
            rd_word = entry_r[2];
        else if (word_addr == ENTRY4_OFS)
            rd_word = entry_r[3];
        else
            rd_word = 32'h0000_0000;
    end

    // Host accesses, then the sequencer; sequencer sets win over host clears
    always_comb
    begin
        logic [31:0] w;
        w = ctrl_word;
        key_high_nxt = key_high_r;
        key_low_nxt = key_low_r;
        ctrl_nxt = ctrl_r;
        go_nxt = go_r;
        ready_nxt = ready_r;
        end_nxt = end_r;
        count_nxt = count_r;
        entry_nxt = entry_r;
        scan_nxt = scan_r;
        state_nxt = state_r;
        tbl_req_nxt = tbl_req_r;
        tbl_req_nxt.wr = 1'b0;
        tbl_req_nxt.rd = 1'b0;
        rdata_nxt = rdata_r;
        advance = 1'b0;
        if (reg_rd)
            rdata_nxt = get_byte(rd_word, reg_addr[1:0]);
        if (reg_rd && reg_addr == ENTRY4_LAST_BYTE)
            ready_nxt = 1'b0;
        if (reg_wr)
        begin
            if (word_addr == KEY_HIGH_OFS)
                key_high_nxt = put_byte(key_high_r, reg_addr[1:0], reg_wdata) & KEY_HIGH_RW_MASK;
            else if (word_addr == KEY_LOW_OFS)
                key_low_nxt = put_byte(key_low_r, reg_addr[1:0], reg_wdata);
            else if (word_addr == ACC_CTRL_OFS && state_r == ST_IDLE && !go_r)
            begin
                w = put_byte(ctrl_word, reg_addr[1:0], reg_wdata);
                ctrl_nxt = w[4:0] & CTRL_RW_MASK;
                go_nxt = w[GO_BIT];
            end
            else if (word_addr == ENTRY1_OFS)
                entry_nxt[0] = put_byte(entry_r[0], reg_addr[1:0], reg_wdata);
            else if (word_addr == ENTRY2_OFS)
                entry_nxt[1] = put_byte(entry_r[1], reg_addr[1:0], reg_wdata);
            else if (word_addr == ENTRY3_OFS)
                entry_nxt[2] = put_byte(entry_r[2], reg_addr[1:0], reg_wdata);
            else if (word_addr == ENTRY4_OFS)
                entry_nxt[3] = put_byte(entry_r[3], reg_addr[1:0], reg_wdata);
        end
        case (state_r)
            ST_IDLE:
            begin
                if (go_r)
                begin
                    case (op_t'(ctrl_r[1:0]))
                        OP_WRITE:
                        begin
                            tbl_req_nxt.wr = 1'b1;
                            tbl_req_nxt.addr = loc;
                            tbl_req_nxt.wdata = {entry_r[0], entry_r[1], entry_r[2],
                                                 entry_r[3]};
                            go_nxt = 1'b0;
                        end
                        OP_READ:
                        begin
                            tbl_req_nxt.rd = 1'b1;
                            tbl_req_nxt.addr = loc;
                            state_nxt = ST_RD_WAIT;
                        end
                        OP_SEARCH:
                        begin
                            tbl_req_nxt.rd = 1'b1;
                            tbl_req_nxt.addr = '0;
                            scan_nxt = '0;
                            count_nxt = COUNT_RST;
                            ready_nxt = 1'b0;
                            end_nxt = 1'b0;
                            state_nxt = ST_SR_WAIT;
                        end
                        default:
                            go_nxt = 1'b0;
                    endcase
                end
            end
            ST_RD_WAIT:
                state_nxt = ST_RD_CAP;
            ST_RD_CAP:
            begin
                {entry_nxt[0], entry_nxt[1], entry_nxt[2], entry_nxt[3]} = tbl_rdata;
                go_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
            ST_SR_WAIT:
                state_nxt = ST_SR_CAP;
            ST_SR_CAP:
            begin
                if (tbl_rdata[ENTRY_VALID_BIT])
                begin
                    {entry_nxt[0], entry_nxt[1], entry_nxt[2], entry_nxt[3]} = tbl_rdata;
                    ready_nxt = 1'b1;
                    count_nxt = count_r + 14'h0001;
                    state_nxt = ST_SR_HOLD;
                end
                else
                    advance = 1'b1;
            end
            ST_SR_HOLD:
                advance = !ready_r;
            default:
                state_nxt = ST_IDLE;
        endcase
        // Step the search or finish it
        if (advance)
        begin
            if (scan_r == TBL_LAST)
            begin
                go_nxt = 1'b0;
                end_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            else
            begin
                scan_nxt = scan_r + 12'h001;
                tbl_req_nxt.rd = 1'b1;
                tbl_req_nxt.addr = scan_r + 12'h001;
                state_nxt = ST_SR_WAIT;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_high_r <= KEY_HIGH_RST;
            key_low_r <= KEY_LOW_RST;
            ctrl_r <= CTRL_RST;
            go_r <= 1'b0;
            ready_r <= 1'b0;
            end_r <= 1'b0;
            count_r <= COUNT_RST;
            for (int i = 0; i < 4; i++)
                entry_r[i] <= ENTRY_RST;
            scan_r <= '0;
            state_r <= ST_IDLE;
            tbl_req_r <= '0;
            rdata_r <= 8'h00;
        end
        else
        begin
            key_high_r <= key_high_nxt;
            key_low_r <= key_low_nxt;
            ctrl_r <= ctrl_nxt;
            go_r <= go_nxt;
            ready_r <= ready_nxt;
            end_r <= end_nxt;
            count_r <= count_nxt;
            entry_r <= entry_nxt;
            scan_r <= scan_nxt;
            state_r <= state_nxt;
            tbl_req_r <= tbl_req_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign tbl_req = tbl_req_r;
    assign reg_rdata = rdata_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic start_w;
    assign start_w = state_r == ST_IDLE && go_r;

    write_done_a: assert property (start_w && ctrl_r[1:0] == OP_WRITE
        |=> tbl_req.wr && !go_r)
        else $error("write did not issue or go bit stuck");
    read_seq_a: assert property (start_w && ctrl_r[1:0] == OP_READ
        |=> tbl_req.rd ##2 !go_r)
        else $error("read sequence timing wrong");
    hash_addr_a: assert property (start_w && !ctrl_r[DIRECT_BIT]
        && ctrl_r[1:0] != OP_NONE && ctrl_r[1:0] != OP_SEARCH
        |=> tbl_req.addr == hash_loc($past(key_high_r[FID_MSB:FID_LSB]),
                                     {$past(key_high_r[MAC_HI_MSB:0]), $past(key_low_r)}))
        else $error("hashed location wrong");
    direct_addr_a: assert property (start_w && ctrl_r[DIRECT_BIT]
        && ctrl_r[1:0] == OP_READ |=> tbl_req.addr == $past(key_low_r[11:0]))
        else $error("direct location wrong");
    ready_clr_a: assert property (ready_r && reg_rd && reg_addr == ENTRY4_LAST_BYTE
        |=> !ready_r)
        else $error("entry ready not cleared by last entry byte read");
    count_step_a: assert property ($rose(ready_r)
        |-> count_r == $past(count_r) + 14'h0001)
        else $error("valid count did not step with a hit");
    search_end_a: assert property ($fell(go_r) && $past(ctrl_r[1:0]) == OP_SEARCH
        |-> ctrl_word[END_BIT])
        else $error("search end not flagged");
    entry_load_a: assert property (state_r == ST_RD_CAP
        |=> entry_r[3] == $past(tbl_rdata[31:0]))
        else $error("read data not loaded into entry registers");
    // A search start clears the count itself, so only idle, unlocked writes are watched
    ro_ignore_a: assert property (reg_wr && word_addr == ACC_CTRL_OFS && !go_r
        && state_r == ST_IDLE |=> count_r == $past(count_r))
        else $error("valid count changed by a host write");

    write_op_c: cover property (start_w && ctrl_r[1:0] == OP_WRITE);
    read_op_c: cover property (state_r == ST_RD_CAP);
    search_hit_c: cover property ($rose(ready_r));
    search_end_c: cover property ($rose(end_r) && count_r != COUNT_RST);

endmodule

`default_nettype wire

// ==== test/table_mem_model.sv ====
// Behavioural table memory standing behind the access port.
// Assumes requests as tbl_req_t and read data due one cycle after the read pulse.
`timescale 1ns/1ps
`default_nettype none

module table_mem_model
    import lookup_access_pkg::*;
(
    // Clock
    input wire logic clk,
    // Requests and read data
    input wire tbl_req_t req,
    output logic [ENTRY_W-1:0] rdata
);
    logic [ENTRY_W-1:0] mem [0:(1<<TBL_AW)-1];

    // Empty table and a defined read bus at start
    initial
    begin
        for (int i = 0; i < (1 << TBL_AW); i++)
            mem[i] = '0;
        rdata = '0;
    end

    // Store, answer once, then invert every idle cycle so stale data only passes on alternate cycles
    always @(posedge clk)
    begin
        if (req.wr)
            mem[req.addr] <= req.wdata;
        if (req.rd)
            rdata <= mem[req.addr];
        else
            rdata <= ~rdata;
    end
endmodule

`default_nettype wire

// ==== test/lookup_table_access_port_tb_top.sv ====
// Self-checking bench of the lookup table access port.
// Assumes the table memory model and a byte-wide host port on one clock.
`timescale 1ns/1ps
`default_nettype none

module lookup_table_access_port_tb_top
    import lookup_access_pkg::*;
;
    localparam logic [15:0] GO_BYTE = ACC_CTRL_OFS + 16'h0003;
    localparam logic [127:0] ENT_A = 128'h8123_4567_89AB_CDEF_0011_2233_4455_6677;
    localparam logic [127:0] ENT_B = 128'h80FE_DCBA_9876_5432_1001_2002_3003_4004;
    localparam logic [127:0] ENT_C = 128'h8A5A_5A5A_C3C3_3C3C_0F0F_F0F0_1357_9BDF;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    tbl_req_t tbl_req;
    logic [ENTRY_W-1:0] tbl_rdata;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] w;
    logic [7:0] b;
    logic [127:0] e;

    // Clock
    always #2 clk = ~clk;

    // Design and table memory
    lookup_table_access_port dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tbl_req(tbl_req), .tbl_rdata(tbl_rdata));
    table_mem_model mem_u (.clk(clk), .req(tbl_req), .rdata(tbl_rdata));

    task automatic conclude();
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Host byte cycles, one idle cycle after a write strobe and two after a read strobe
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // Big-endian words: lowest address carries bits 31:24
    task automatic wr_word(input logic [15:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++)
            wr_byte(a + 16'(i), d[31-8*i -: 8]);
    endtask

    task automatic rd_word(input logic [15:0] a, output logic [31:0] d);
        logic [7:0] x;
        for (int i = 0; i < 4; i++)
        begin
            rd_byte(a + 16'(i), x);
            d[31-8*i -: 8] = x;
        end
    endtask

    task automatic wr_entry(input logic [127:0] v);
        for (int i = 0; i < 4; i++)
            wr_word(ENTRY1_OFS + 16'(4*i), v[127-32*i -: 32]);
    endtask

    task automatic rd_entry(output logic [127:0] v);
        logic [31:0] x;
        for (int i = 0; i < 4; i++)
        begin
            rd_word(ENTRY1_OFS + 16'(4*i), x);
            v[127-32*i -: 32] = x;
        end
    endtask

    // Start an operation and poll the go bit until it clears
    task automatic run_op(input logic [7:0] c);
        wr_byte(GO_BYTE, c);
        for (int i = 0; i < 50; i++)
        begin
            rd_byte(GO_BYTE, b);
            if (b[GO_BIT] === 1'b0)
                break;
        end
        check(128'(b), 128'(c & 8'h07));
    endtask

    // Reference fold of group id and MAC key into a location
    function automatic logic [11:0] fold(input logic [59:0] k);
        return k[11:0] ^ k[23:12] ^ k[35:24] ^ k[47:36] ^ k[59:48];
    endfunction

    task automatic t_reset();
        rd_word(KEY_HIGH_OFS, w);
        check(128'(w), 128'h0);
        rd_word(KEY_LOW_OFS, w);
        check(128'(w), 128'h0);
        rd_word(ACC_CTRL_OFS, w);
        check(128'(w), 128'h0);
    endtask

    // Read-only fields, reserved bits and an unmapped address
    task automatic t_ro();
        wr_word(KEY_HIGH_OFS, 32'hFFFF_0000);
        rd_word(KEY_HIGH_OFS, w);
        check(128'(w), 128'h807F_0000);
        wr_word(ACC_CTRL_OFS, 32'hFFFF_FF60);
        rd_word(ACC_CTRL_OFS, w);
        check(128'(w), 128'h0);
        wr_byte(16'h0500, 8'hA5);
        rd_byte(16'h0500, b);
        check(128'(b), 128'h0);
    endtask

    // Direct write, direct read, hashed write, hashed read and the idle code
    task automatic t_ops();
        wr_word(KEY_LOW_OFS, 32'hFFFF_F123);
        wr_entry(ENT_A);
        run_op(8'h85);
        check(mem_u.mem[12'h123], ENT_A);
        mem_u.mem[12'h456] = ENT_B;
        wr_word(KEY_LOW_OFS, 32'h0000_0456);
        run_op(8'h86);
        rd_entry(e);
        check(e, ENT_B);
        wr_word(KEY_HIGH_OFS, 32'h002A_1234);
        wr_word(KEY_LOW_OFS, 32'h5678_9ABC);
        wr_entry(ENT_C);
        run_op(8'h81);
        check(mem_u.mem[fold({5'h00, 7'h2A, 48'h1234_5678_9ABC})], ENT_C);
        wr_entry(ENT_A);
        run_op(8'h82);
        rd_entry(e);
        check(e, ENT_C);
        run_op(8'h80);
    endtask

    // Search over the three valid entries, with a refused write while busy
    task automatic t_search();
        int hits;
        hits = 0;
        wr_byte(GO_BYTE, 8'h83);
        wr_byte(GO_BYTE, 8'h00);
        rd_byte(GO_BYTE, b);
        check(128'(b[GO_BIT]), 128'h1);
        for (int i = 0; i < 20000; i++)
        begin
            rd_byte(GO_BYTE, b);
            if (b[READY_BIT] === 1'b1)
            begin
                hits++;
                check(128'(b[END_BIT]), 128'h1);
                rd_byte(ENTRY1_OFS, b);
                check(128'(b[7]), 128'h1);
                rd_byte(ENTRY4_LAST_BYTE, b);
            end
            else if (b[GO_BIT] === 1'b0)
                break;
        end
        check(128'(b), 128'h23);
        check(128'(hits), 128'h3);
        rd_word(ACC_CTRL_OFS, w);
        check(128'(w[29:16]), 128'h3);
        wr_word(ACC_CTRL_OFS, 32'hFFFF_FF60);
        rd_word(ACC_CTRL_OFS, w);
        check(128'(w), 128'h0003_0020);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_ro();
        t_ops();
        t_search();
        conclude();
    end

    // Watchdog
    initial
    begin
        #(4 * 60000);
        n_fail++;
        conclude();
    end
endmodule

`default_nettype wire
